// >>> eps_pkg.sv
// Shared constants and types for the e-paper serial control block
package eps_pkg;

  // ==========================================================
  // Word framing
  localparam int EPS_BYTE_W = 8;
  localparam int EPS_WORD3_W = 9;
  localparam int EPS_CNT_W = 4;
  localparam logic [3:0] EPS_LAST_BIT_4W = 4'h7;
  localparam logic [3:0] EPS_LAST_BIT_3W = 4'h8;
  localparam logic [3:0] EPS_LOAD_CNT_4W = 4'h0;
  localparam logic [3:0] EPS_LOAD_CNT_3W = 4'h1;
  localparam int EPS_FLAG_BIT_3W = 8;
  localparam logic [7:0] EPS_IDLE_BYTE = 8'h00;

  // ==========================================================
  // Bus mode selected by the strap
  typedef enum logic [1:0] {
    EPS_MODE_4W = 2'b01,
    EPS_MODE_3W = 2'b10
  } eps_mode_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } eps_rx_word_t;

  typedef struct packed {
    logic waveform_active;
    logic sensor_active;
  } eps_work_t;

endpackage : eps_pkg

// >>> eps_serial_ctrl.sv
// Serial control port of the e-paper panel driver: SPI slave, reset and busy
`timescale 1ns/1ps

// Notes on behaviour
// (R1) Serial traffic accepted only while select low
// (R2) Data-select high marks a data byte
// (R3) Data-select low marks a command byte
// (R4) Reset pin low holds device in reset
// (R5) Host waits for busy low before commands
// (R6) Busy high during waveform or sensor work
// (R7) Strap low 4-wire, high 3-wire 9-bit
// (R8) 4-wire: 8 bits on rising edges, MSB first
// (R9) 3-wire: flag bit then byte, MSB first
// (R10) Read bytes shifted out on falling edges
module eps_serial_ctrl
  import eps_pkg::*;
(
  // System clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dc,
  input wire logic serial_in,
  input wire logic reset_in_n,
  input wire logic bus_mode_strap,
  output logic serial_out,
  output logic serial_out_oe,
  output logic busy,
  // Core side: received words
  output eps_rx_word_t rx_word,
  output logic rx_cmd_valid,
  output logic rx_data_valid,
  // Core side: read data
  input wire logic rd_enable,
  input wire logic tx_load,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  output logic tx_taken,
  // Core side: status and control
  input wire eps_work_t work,
  output logic core_reset_n,
  output eps_mode_t bus_mode
);

  // ==========================================================
  // Link domain reset: select high, reset pin or system reset
  logic link_rst_n;
  assign link_rst_n = ~cs_n & reset_in_n & rstn; // (R1) (R4)

  // ==========================================================
  // Link domain: slow-level synchronisers
  logic strap_s1_q;
  logic strap_s2_q;
  logic rden_s1_q;
  logic rden_s2_q;

  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      rden_s1_q <= 1'b0;
      rden_s2_q <= 1'b0;
    end else begin
      strap_s1_q <= bus_mode_strap;
      strap_s2_q <= strap_s1_q;
      rden_s1_q <= rd_enable;
      rden_s2_q <= rden_s1_q;
    end
  end

  logic link_3w;
  assign link_3w = strap_s2_q;

  // ==========================================================
  // Link domain: receive shifter on rising edges
  logic [EPS_CNT_W-1:0] bit_cnt_q;
  logic [EPS_WORD3_W-1:0] rx_sh_q;
  logic [EPS_WORD3_W-1:0] rx_sh_d;
  logic [EPS_CNT_W-1:0] last_bit;
  logic word_end;
  logic cmd_seen_q;
  eps_rx_word_t link_word_q;
  logic rx_tgl_q;

  assign rx_sh_d = {rx_sh_q[EPS_WORD3_W-2:0], serial_in}; // (R8) (R9)
  assign last_bit = link_3w ? EPS_LAST_BIT_3W : EPS_LAST_BIT_4W; // (R7)
  assign word_end = (bit_cnt_q == last_bit);

  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_q <= '0;
      rx_sh_q <= '0;
    end else begin
      rx_sh_q <= rx_sh_d;
      if (word_end) begin
        bit_cnt_q <= '0;
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end

  // First word of each frame is the command of a read
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cmd_seen_q <= 1'b0;
    end else if (word_end) begin
      cmd_seen_q <= 1'b1;
    end
  end

  // Completed word is held until the next one ends
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      link_word_q <= '0;
      rx_tgl_q <= 1'b0;
    end else if (word_end && !cs_n && reset_in_n) begin // (R1)
      link_word_q.value <= rx_sh_d[EPS_BYTE_W-1:0]; // (R8) (R9)
      if (link_3w) begin
        link_word_q.is_data <= rx_sh_d[EPS_FLAG_BIT_3W]; // (R9)
      end else begin
        link_word_q.is_data <= dc; // (R2) (R3) (R8)
      end
      rx_tgl_q <= ~rx_tgl_q;
    end
  end

  // ==========================================================
  // Link domain: read shifter on falling edges
  logic req_s1_q;
  logic req_s2_q;
  logic ack_tgl_q;
  logic [EPS_BYTE_W-1:0] tx_sh_q;
  logic out_q;
  logic oe_q;
  logic load_pt;
  logic tx_req_tgl_q;
  logic [EPS_BYTE_W-1:0] tx_hold_q;

  assign load_pt = cmd_seen_q &&
                   (bit_cnt_q == (link_3w ? EPS_LOAD_CNT_3W : EPS_LOAD_CNT_4W)); // (R10)

  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= tx_req_tgl_q;
      req_s2_q <= req_s1_q;
    end
  end

  // Byte taken from holding word only while request is pending
  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      ack_tgl_q <= 1'b0;
    end else if (load_pt && rden_s2_q && !cs_n && (req_s2_q != ack_tgl_q)) begin
      ack_tgl_q <= ~ack_tgl_q;
    end
  end

  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_sh_q <= EPS_IDLE_BYTE;
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (load_pt && rden_s2_q) begin
      if (req_s2_q != ack_tgl_q) begin
        tx_sh_q <= {tx_hold_q[EPS_BYTE_W-2:0], 1'b0}; // (R10)
        out_q <= tx_hold_q[EPS_BYTE_W-1]; // (R10)
      end else begin
        tx_sh_q <= EPS_IDLE_BYTE;
        out_q <= 1'b0;
      end
      oe_q <= 1'b1;
    end else begin
      tx_sh_q <= {tx_sh_q[EPS_BYTE_W-2:0], 1'b0}; // (R10)
      out_q <= tx_sh_q[EPS_BYTE_W-1];
    end
  end

  assign serial_out = out_q;
  assign serial_out_oe = oe_q;

  // ==========================================================
  // System domain: reset pin and strap
  logic rst_s1_q;
  logic rst_s2_q;
  logic core_rst_n_q;
  logic strap_c1_q;
  logic strap_c2_q;
  eps_mode_t mode_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
      core_rst_n_q <= 1'b0;
      strap_c1_q <= 1'b0;
      strap_c2_q <= 1'b0;
    end else begin
      rst_s1_q <= reset_in_n;
      rst_s2_q <= rst_s1_q;
      core_rst_n_q <= rst_s2_q; // (R4)
      strap_c1_q <= bus_mode_strap;
      strap_c2_q <= strap_c1_q;
    end
  end

  // Mode follows the strap while in reset, then freezes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= EPS_MODE_4W;
    end else if (!core_rst_n_q) begin
      mode_q <= strap_c2_q ? EPS_MODE_3W : EPS_MODE_4W; // (R7)
    end
  end

  assign core_reset_n = core_rst_n_q;
  assign bus_mode = mode_q;

  // ==========================================================
  // System domain: busy
  logic busy_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b1;
    end else begin
      busy_q <= !core_rst_n_q || work.waveform_active || work.sensor_active; // (R6) (R5)
    end
  end

  assign busy = busy_q;

  // ==========================================================
  // System domain: received word handover
  logic rxt_s1_q;
  logic rxt_s2_q;
  logic rxt_s3_q;
  eps_rx_word_t rx_word_q;
  logic rx_cmd_q;
  logic rx_data_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxt_s1_q <= 1'b0;
      rxt_s2_q <= 1'b0;
      rxt_s3_q <= 1'b0;
    end else begin
      rxt_s1_q <= rx_tgl_q;
      rxt_s2_q <= rxt_s1_q;
      rxt_s3_q <= rxt_s2_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_word_q <= '0;
      rx_cmd_q <= 1'b0;
      rx_data_q <= 1'b0;
    end else if (!core_rst_n_q) begin
      rx_cmd_q <= 1'b0;
      rx_data_q <= 1'b0;
    end else begin
      rx_cmd_q <= 1'b0;
      rx_data_q <= 1'b0;
      if (rxt_s2_q != rxt_s3_q) begin
        rx_word_q <= link_word_q;
        rx_data_q <= link_word_q.is_data; // (R2)
        rx_cmd_q <= !link_word_q.is_data; // (R3)
      end
    end
  end

  assign rx_word = rx_word_q;
  assign rx_cmd_valid = rx_cmd_q;
  assign rx_data_valid = rx_data_q;

  // ==========================================================
  // System domain: read byte handshake
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_s3_q;
  logic tx_free_q;
  logic tx_taken_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  // Holding byte stays still while a request is outstanding
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_hold_q <= EPS_IDLE_BYTE;
      tx_req_tgl_q <= 1'b0;
      tx_free_q <= 1'b1;
      tx_taken_q <= 1'b0;
    end else begin
      tx_taken_q <= 1'b0;
      if (ack_s2_q != ack_s3_q) begin
        tx_free_q <= 1'b1;
        tx_taken_q <= 1'b1;
      end else if (tx_load && tx_free_q && core_rst_n_q) begin
        tx_hold_q <= tx_byte;
        tx_req_tgl_q <= ~tx_req_tgl_q;
        tx_free_q <= 1'b0;
      end
    end
  end

  assign tx_ready = tx_free_q;
  assign tx_taken = tx_taken_q;

endmodule // eps_serial_ctrl

// >>> eps_chk_sva.sv
// Checker for the e-paper serial control block
`timescale 1ns/1ps
module eps_chk
  import eps_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic rstn,
  input wire logic busy,
  input wire logic core_reset_n,
  input wire logic rx_cmd_valid,
  input wire logic rx_data_valid,
  input wire eps_rx_word_t rx_word,
  input wire logic tx_load,
  input wire logic tx_ready,
  input wire eps_work_t work,
  input wire eps_mode_t bus_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_vld;
    rx_cmd_valid || rx_data_valid;
  endsequence
  property p_work; work != 2'h0 |=> busy; endproperty
  a_work: assert property (p_work) else $error("busy low while working");
  property p_core; !core_reset_n |=> busy; endproperty
  a_core: assert property (p_core) else $error("busy low in reset");
  property p_cmd; rx_cmd_valid |-> !rx_data_valid && !rx_word.is_data; endproperty
  a_cmd: assert property (p_cmd) else $error("command word flagged as data");
  property p_data; rx_data_valid |-> rx_word.is_data; endproperty
  a_data: assert property (p_data) else $error("data word flagged as command");
  property p_pulse; s_vld |=> !rx_cmd_valid && !rx_data_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("word strobe too long");
  property p_hold; core_reset_n && $changed(rx_word) |-> s_vld; endproperty
  a_hold: assert property (p_hold) else $error("word changed without strobe");
  property p_tx; tx_load && tx_ready && core_reset_n |=> !tx_ready; endproperty
  a_tx: assert property (p_tx) else $error("read byte not held");
  property p_mode; core_reset_n && $past(core_reset_n) |-> $stable(bus_mode); endproperty
  a_mode: assert property (p_mode) else $error("bus mode moved out of reset");
endmodule // eps_chk

bind eps_serial_ctrl eps_chk i_eps_chk (.clk, .rstn, .busy, .core_reset_n, .rx_cmd_valid,
  .rx_data_valid, .rx_word, .tx_load, .tx_ready, .work, .bus_mode);

// >>> eps_host_model.sv
// Host microcontroller model for the serial control pins
`timescale 1ns/1ps
module eps_host_model (
  // Host pins
  output logic sclk,
  output logic cs_n,
  output logic dc,
  output logic serial_in,
  // Read-back pins
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dc = 1'b0;
    serial_in = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) begin
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
  endtask
  task automatic sel(input logic on);
    #43 cs_n = ~on;
    #80;
  endtask
  task automatic word(input logic [8:0] w, input int n, input logic d, output logic [7:0] r);
    dc = d;
    r = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #80 sclk = 1'b1;
      r = {r[6:0], (serial_out_oe === 1'b1) ? serial_out : ~serial_out};
      #80 sclk = 1'b0;
    end
    serial_in = ~serial_in;
  endtask
endmodule // eps_host_model

// >>> tb_eps_serial_ctrl.sv
// Testbench for the e-paper serial control block
`timescale 1ns/1ps
module tb_eps_serial_ctrl;
  import eps_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, reset_in_n = 1'b1, bus_mode_strap = 1'b0;
  logic rd_enable = 1'b0, tx_load = 1'b0;
  logic [7:0] tx_byte = 8'h00, r;
  eps_work_t work = '0;
  logic sclk, cs_n, dc, serial_in, serial_out, serial_out_oe, busy;
  logic rx_cmd_valid, rx_data_valid, tx_ready, tx_taken, core_reset_n;
  eps_rx_word_t rx_word, q[$];
  eps_mode_t bus_mode;
  int n_mismatch = 0, n_compared = 0;
  always #5 clk = ~clk;
  int n_taken = 0;
  always @(posedge clk) if (tx_taken === 1'b1) n_taken++;
  always @(posedge clk) if ((rx_cmd_valid | rx_data_valid) === 1'b1) begin
    q.push_back(rx_word);
    check({rx_cmd_valid, rx_data_valid}, {~rx_word.is_data, rx_word.is_data});
  end
  eps_serial_ctrl i_eps_serial_ctrl (.clk, .rstn, .sclk, .cs_n, .dc, .serial_in, .reset_in_n,
    .bus_mode_strap, .serial_out, .serial_out_oe, .busy, .rx_word, .rx_cmd_valid,
    .rx_data_valid, .rd_enable, .tx_load, .tx_byte, .tx_ready, .tx_taken, .work,
    .core_reset_n, .bus_mode);
  eps_host_model i_eps_host_model (.sclk, .cs_n, .dc, .serial_in, .serial_out, .serial_out_oe);
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bail(input int i, input int lim);
    if (i >= lim) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 99 && busy !== 1'b0; i++) @(posedge clk);
    bail(i, 99);
  endtask
  task automatic exp_word(input logic [8:0] e);
    int i;
    for (i = 0; i < 30 && q.size() == 0; i++) @(posedge clk);
    bail(i, 30);
    check(q.pop_front(), e);
  endtask
  task automatic cs(input logic on);
    i_eps_host_model.sel(on);
  endtask
  task automatic tx(input logic [8:0] w, input int n, input logic d);
    i_eps_host_model.word(w, n, d, r);
  endtask
  task automatic t_reset();
    cyc(9);
    check({busy, core_reset_n, tx_ready, bus_mode}, {3'b101, EPS_MODE_4W});
    @(posedge clk) rstn <= 1'b1;
    i_eps_host_model.tick(3);
    wait_idle();
    $display("reset test done");
  endtask
  task automatic t_write4();
    wait_idle();
    cs(1'b1);
    tx(9'h0A5, 8, 1'b0);
    tx(9'h05A, 8, 1'b1);
    cs(1'b0);
    exp_word(9'h0A5);
    exp_word(9'h15A);
    tx(9'h0FF, 8, 1'b1);
    cs(1'b1);
    tx(9'h00F, 4, 1'b1);
    cs(1'b0);
    cs(1'b1);
    tx(9'h03C, 8, 1'b0);
    cs(1'b0);
    exp_word(9'h03C);
    cyc(20);
    check(9'(q.size()), 9'h000);
    $display("write test done");
  endtask
  task automatic t_busy();
    @(posedge clk) work <= 2'b10;
    cyc(2);
    check(busy, 1'b1);
    @(posedge clk) work <= 2'b01;
    cyc(2);
    check(busy, 1'b1);
    @(posedge clk) work <= 2'b00;
    wait_idle();
    $display("busy test done");
  endtask
  task automatic t_read();
    @(posedge clk) rd_enable <= 1'b1;
    i_eps_host_model.tick(3);
    @(posedge clk) tx_byte <= 8'h3C;
    tx_load <= 1'b1;
    @(posedge clk) tx_load <= 1'b0;
    cyc(1);
    check(tx_ready, 1'b0);
    wait_idle();
    cs(1'b1);
    tx(9'h0B1, 8, 1'b0);
    tx(9'h000, 8, 1'b1);
    check(r, 8'h3C);
    tx(9'h000, 8, 1'b1);
    check(r, 8'h00);
    check(serial_out_oe, 1'b1);
    cs(1'b0);
    cyc(8);
    check({serial_out_oe, tx_ready}, 2'b01);
    check(9'(n_taken), 9'h001);
    @(posedge clk) rd_enable <= 1'b0;
    i_eps_host_model.tick(3);
    exp_word(9'h0B1);
    exp_word(9'h100);
    exp_word(9'h100);
    $display("read test done");
  endtask
  task automatic t_mode3();
    @(posedge clk) reset_in_n <= 1'b0;
    bus_mode_strap <= 1'b1;
    cyc(6);
    check({core_reset_n, busy}, 2'b01);
    @(posedge clk) reset_in_n <= 1'b1;
    i_eps_host_model.tick(3);
    wait_idle();
    check(bus_mode, EPS_MODE_3W);
    cs(1'b1);
    tx(9'h0C3, 9, 1'b0);
    tx(9'h181, 9, 1'b0);
    cs(1'b0);
    exp_word(9'h0C3);
    exp_word(9'h181);
    $display("three-wire test done");
  endtask
  initial begin
    t_reset();
    t_write4();
    t_busy();
    t_read();
    t_mode3();
    final_report();
  end
endmodule // tb_eps_serial_ctrl
